// ---- verilog/spio_pkg.sv ----
// Package for the shared parallel I/O ports: widths, port indices, pin masks, bit positions and carrier structs.
package spio_pkg;

  // ----------------------------------------------------------------
  // Port geometry
  // ----------------------------------------------------------------
  localparam int unsigned SPIO_NPORTS = 5;
  localparam int unsigned SPIO_W = 8;
  localparam int unsigned SPIO_PA = 0;
  localparam int unsigned SPIO_PB = 1;
  localparam int unsigned SPIO_PC = 2;
  localparam int unsigned SPIO_PD = 3;
  localparam int unsigned SPIO_PE = 4;
  // Fourth port has seven pins; this mask keeps bit 7 unimplemented.
  localparam logic [7:0] SPIO_PD_MASK = 8'h7f;
  // First port bit 0 has no output driver.
  localparam logic [7:0] SPIO_PA_OUT_MASK = 8'hfe;
  localparam logic [7:0] SPIO_BYTE_ZERO = 8'h00;
  localparam logic [7:0] SPIO_BYTE_ONES = 8'hff;

  // ----------------------------------------------------------------
  // Bit positions of shared functions
  // ----------------------------------------------------------------
  localparam int unsigned SPIO_SCI_TX_BIT = 0;
  localparam int unsigned SPIO_SCI_RX_BIT = 1;
  localparam int unsigned SPIO_TMR1_BIT = 7;
  localparam int unsigned SPIO_SPI_SS_BIT = 7;
  localparam int unsigned SPIO_SPI_CLK_BIT = 6;
  localparam int unsigned SPIO_SPI_MISO_BIT = 5;
  localparam int unsigned SPIO_SPI_MOSI_BIT = 4;
  localparam int unsigned SPIO_BKGD_BIT = 0;
  localparam int unsigned SPIO_RST_BIT = 1;
  localparam int unsigned SPIO_TMR0_BIT = 6;
  localparam logic [7:0] SPIO_FIRST_KEYPAD_INTERRUPT_UNIT_HI_MASK = 8'hf0;
  localparam logic [7:0] SPIO_SECOND_KEYPAD_INTERRUPT_UNIT_MASK = 8'h0f;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef logic [SPIO_NPORTS-1:0][SPIO_W-1:0] spio_bytes_type;

  // One software write strobe per port, data and which register.
  typedef struct packed {
    logic [SPIO_NPORTS-1:0] wr_data;
    logic [SPIO_NPORTS-1:0] wr_dir;
    logic [SPIO_NPORTS-1:0] wr_pull;
    logic [SPIO_W-1:0] wdata;
  } spio_wr_type;

  // Peripheral claims on the pins; timer, SPI and background functions say whether they drive.
  typedef struct packed {
    logic [7:0] first_keypad_interrupt_unit_en;
    logic [7:0] first_keypad_interrupt_unit_rise;
    logic [3:0] second_keypad_interrupt_unit_en;
    logic sci_en;
    logic sci_tx;
    logic tmr1_en;
    logic tmr1_oe;
    logic tmr1_out;
    logic spi_en;
    logic [3:0] spi_oe;
    logic [3:0] spi_out;
    logic tmr0_en;
    logic tmr0_oe;
    logic tmr0_out;
    logic bkgd_oe;
    logic bkgd_out;
    logic bkgd_release;
  } spio_periph_type;

  // Pad controls: drive level, driver enable, pullup and pulldown.
  typedef struct packed {
    spio_bytes_type out;
    spio_bytes_type oe;
    spio_bytes_type pu;
    spio_bytes_type pd;
  } spio_pad_type;

  // State of the port block, apart from the mode strap sampler.
  typedef struct packed {
    spio_bytes_type dat;
    spio_bytes_type dir;
    spio_bytes_type pull;
    logic bkgd_own;
    spio_bytes_type sync1;
    spio_bytes_type sync2;
    spio_bytes_type rd;
    spio_pad_type pad;
    logic mode_sel;
  } spio_state_type;

endpackage : spio_pkg

// ---- verilog/spio_ports.sv ----
// Shared parallel I/O ports: data latches, direction, pullups and peripheral overrides.
//
// Behaviour
// - Thirty-nine pins: four eight-bit, one seven-bit port.
// - First port bit 0 is input only.
// - All first port pins feed first keypad unit.
// - Serial enabled: second port bits 0,1 transmit/receive.
// - Second port bit 7 serves timer channel one.
// - SPI enabled: third port bits 7..4 SPI.
// - Third port bits 3..0 feed second keypad unit.
// - Fourth port bit 0 starts as background pin.
// - Background owning pin forces its pullup on.
// - Mode select in reset, background pin afterwards.
// - Software may reassign that pin as output only.
// - Fourth port bit 1 always serves reset function.
// - Fourth port bit 6 serves timer channel zero.
// - Plain GPIO only when no peripheral controls pin.
// - Data read: pin if input, latch if output.
// - Data writes always update the latch.
// - Drive latch only for unclaimed output pins.
// - Direction bit still selects read source under override.
// - Fourth port bits 0,1 always read pin level.
// - Pullup enable acts only while direction is input.
// - Pullup also serves peripheral inputs when direction input.
// - Reset clears latches; pins inputs, pullups off except the background pin's.
// - Rising keypad inputs on bits 7..4 use pulldowns.
module spio_ports
  import spio_pkg::*;
(
  // Clock, reset and enable
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_ce,
  // Software register access
  input wire spio_wr_type i_wr,
  input wire logic i_bkgd_to_gpio,
  // Sharing peripherals
  input wire spio_periph_type i_periph,
  // Pad inputs
  input wire spio_bytes_type i_pin,
  // Register read-back
  output spio_bytes_type o_rd_data,
  output spio_bytes_type o_rd_dir,
  output spio_bytes_type o_rd_pull,
  output logic o_bkgd_own,
  output logic o_mode_select,
  // Synchronised pin levels to peripherals
  output spio_bytes_type o_pin_sync,
  // Pad controls
  output spio_pad_type o_pad
);

  spio_state_type cur_ff;
  spio_state_type nxt_cur;

  // ----------------------------------------------------------------
  // Pin ownership
  // ----------------------------------------------------------------
  // Per pin: claimed by a peripheral, peripheral drives it, and its level.
  spio_bytes_type claim;
  spio_bytes_type p_oe;
  spio_bytes_type p_out;
  spio_bytes_type p_in;
  spio_bytes_type impl_mask;
  spio_bytes_type drv_mask;

  // Implemented bits and bits that have an output driver.
  always_comb begin
    impl_mask = '{default: SPIO_BYTE_ONES};
    impl_mask[SPIO_PD] = SPIO_PD_MASK;
    drv_mask = impl_mask;
    drv_mask[SPIO_PA] = SPIO_PA_OUT_MASK;
  end

  // Peripheral claims; keypad inputs claim only for input-side use.
  always_comb begin
    claim = '0;
    p_oe = '0;
    p_out = '0;
    p_in = '0;
    claim[SPIO_PA] = i_periph.first_keypad_interrupt_unit_en;
    p_in[SPIO_PA] = i_periph.first_keypad_interrupt_unit_en;
    claim[SPIO_PC][3:0] = i_periph.second_keypad_interrupt_unit_en;
    p_in[SPIO_PC][3:0] = i_periph.second_keypad_interrupt_unit_en;
    if (i_periph.sci_en) begin
      claim[SPIO_PB][SPIO_SCI_TX_BIT] = 1'b1;
      p_oe[SPIO_PB][SPIO_SCI_TX_BIT] = 1'b1;
      p_out[SPIO_PB][SPIO_SCI_TX_BIT] = i_periph.sci_tx;
      claim[SPIO_PB][SPIO_SCI_RX_BIT] = 1'b1;
      p_in[SPIO_PB][SPIO_SCI_RX_BIT] = 1'b1;
    end
    if (i_periph.tmr1_en) begin
      claim[SPIO_PB][SPIO_TMR1_BIT] = 1'b1;
      p_oe[SPIO_PB][SPIO_TMR1_BIT] = i_periph.tmr1_oe;
      p_out[SPIO_PB][SPIO_TMR1_BIT] = i_periph.tmr1_out;
      p_in[SPIO_PB][SPIO_TMR1_BIT] = ~i_periph.tmr1_oe;
    end
    if (i_periph.spi_en) begin
      claim[SPIO_PC][SPIO_SPI_SS_BIT:SPIO_SPI_MOSI_BIT] = 4'hf;
      p_oe[SPIO_PC][SPIO_SPI_SS_BIT:SPIO_SPI_MOSI_BIT] = i_periph.spi_oe;
      p_out[SPIO_PC][SPIO_SPI_SS_BIT:SPIO_SPI_MOSI_BIT] = i_periph.spi_out;
      p_in[SPIO_PC][SPIO_SPI_SS_BIT:SPIO_SPI_MOSI_BIT] = ~i_periph.spi_oe;
    end
    if (i_periph.tmr0_en) begin
      claim[SPIO_PD][SPIO_TMR0_BIT] = 1'b1;
      p_oe[SPIO_PD][SPIO_TMR0_BIT] = i_periph.tmr0_oe;
      p_out[SPIO_PD][SPIO_TMR0_BIT] = i_periph.tmr0_out;
      p_in[SPIO_PD][SPIO_TMR0_BIT] = ~i_periph.tmr0_oe;
    end
    // The reset pin is never handed back to the port logic.
    claim[SPIO_PD][SPIO_RST_BIT] = 1'b1;
    p_in[SPIO_PD][SPIO_RST_BIT] = 1'b1;
    if (cur_ff.bkgd_own) begin
      claim[SPIO_PD][SPIO_BKGD_BIT] = 1'b1;
      p_oe[SPIO_PD][SPIO_BKGD_BIT] = i_periph.bkgd_oe;
      p_out[SPIO_PD][SPIO_BKGD_BIT] = i_periph.bkgd_out;
      p_in[SPIO_PD][SPIO_BKGD_BIT] = ~i_periph.bkgd_oe;
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_cur = cur_ff;
    // Two-stage synchroniser; only the second stage is looked at.
    nxt_cur.sync1 = i_pin;
    nxt_cur.sync2 = cur_ff.sync1;
    // Mode select field keeps its reset value; the strap sampler below catches the level.
    nxt_cur.mode_sel = cur_ff.mode_sel;
    // Software hands the background pin over; a one-way move until reset.
    if (i_bkgd_to_gpio) begin
      nxt_cur.bkgd_own = 1'b0;
    end
    for (int p = 0; p < SPIO_NPORTS; p++) begin
      // Latch takes every write, claimed or input pin alike.
      if (i_wr.wr_data[p]) begin
        nxt_cur.dat[p] = i_wr.wdata & impl_mask[p];
      end
      if (i_wr.wr_dir[p]) begin
        nxt_cur.dir[p] = i_wr.wdata & impl_mask[p];
      end
      if (i_wr.wr_pull[p]) begin
        nxt_cur.pull[p] = i_wr.wdata & impl_mask[p];
      end
      for (int b = 0; b < SPIO_W; b++) begin
        // Direction alone picks the read source, even under override.
        nxt_cur.rd[p][b] = cur_ff.dir[p][b] ? cur_ff.dat[p][b] : cur_ff.sync2[p][b];
        // Default pad state: undriven, no pull devices.
        nxt_cur.pad.oe[p][b] = 1'b0;
        nxt_cur.pad.out[p][b] = 1'b0;
        nxt_cur.pad.pu[p][b] = 1'b0;
        nxt_cur.pad.pd[p][b] = 1'b0;
        if (claim[p][b]) begin
          nxt_cur.pad.oe[p][b] = p_oe[p][b] & drv_mask[p][b];
          nxt_cur.pad.out[p][b] = p_out[p][b];
          // Pull devices serve peripheral inputs while direction is input.
          nxt_cur.pad.pu[p][b] = p_in[p][b] & ~cur_ff.dir[p][b] & cur_ff.pull[p][b];
        end else begin
          nxt_cur.pad.oe[p][b] = cur_ff.dir[p][b] & drv_mask[p][b];
          nxt_cur.pad.out[p][b] = cur_ff.dat[p][b] & drv_mask[p][b];
          nxt_cur.pad.pu[p][b] = ~cur_ff.dir[p][b] & cur_ff.pull[p][b];
        end
      end
      // Unimplemented bits read zero.
      nxt_cur.rd[p] = nxt_cur.rd[p] & impl_mask[p];
    end
    // Rising-sense keypad inputs on bits 7..4 turn the pullup request into a pulldown.
    for (int b = 0; b < SPIO_W; b++) begin
      if (SPIO_FIRST_KEYPAD_INTERRUPT_UNIT_HI_MASK[b] && i_periph.first_keypad_interrupt_unit_en[b] && i_periph.first_keypad_interrupt_unit_rise[b]) begin
        nxt_cur.pad.pd[SPIO_PA][b] = nxt_cur.pad.pu[SPIO_PA][b];
        nxt_cur.pad.pu[SPIO_PA][b] = 1'b0;
      end
    end
    // Background pin always pulled up while its function owns it.
    if (cur_ff.bkgd_own) begin
      nxt_cur.pad.pu[SPIO_PD][SPIO_BKGD_BIT] = 1'b1;
    end else begin
      // Output-only once reassigned: driver on, no pull, data from latch.
      nxt_cur.pad.oe[SPIO_PD][SPIO_BKGD_BIT] = 1'b1;
      nxt_cur.pad.out[SPIO_PD][SPIO_BKGD_BIT] = cur_ff.dat[SPIO_PD][SPIO_BKGD_BIT];
      nxt_cur.pad.pu[SPIO_PD][SPIO_BKGD_BIT] = 1'b0;
    end
    // These two pins always read the pin level.
    nxt_cur.rd[SPIO_PD][SPIO_BKGD_BIT] = cur_ff.sync2[SPIO_PD][SPIO_BKGD_BIT];
    nxt_cur.rd[SPIO_PD][SPIO_RST_BIT] = cur_ff.sync2[SPIO_PD][SPIO_RST_BIT];
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Reset: latches zero, all inputs, no pulls, background owns its pin,
  // but its pullup is on from the first cycle so the mode strap floats high.
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      cur_ff <= '0;
      cur_ff.bkgd_own <= 1'b1;
      cur_ff.pad.pu[SPIO_PD][SPIO_BKGD_BIT] <= 1'b1;
    end else if (i_ce) begin
      cur_ff <= nxt_cur;
    end
  end

  // Mode strap caught after reset release, from the synchronised pin.
  logic strap_done_ff;
  logic nxt_strap_done;
  logic strap_level_ff;
  logic nxt_strap_level;
  logic [1:0] strap_wait_ff;
  logic [1:0] nxt_strap_wait;

  // Wait three cycles for the two synchroniser stages to fill, then sample once.
  always_comb begin
    nxt_strap_done = strap_done_ff;
    nxt_strap_level = strap_level_ff;
    nxt_strap_wait = strap_wait_ff;
    if (!strap_done_ff) begin
      if (&strap_wait_ff) begin
        nxt_strap_done = 1'b1;
        nxt_strap_level = cur_ff.sync2[SPIO_PD][SPIO_BKGD_BIT];
      end else begin
        nxt_strap_wait = strap_wait_ff + 2'h1;
      end
    end
  end

  // Strap sampler registers.
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      strap_done_ff <= 1'b0;
      strap_level_ff <= 1'b0;
      strap_wait_ff <= 2'h0;
    end else if (i_ce) begin
      strap_done_ff <= nxt_strap_done;
      strap_level_ff <= nxt_strap_level;
      strap_wait_ff <= nxt_strap_wait;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all from flip-flops
  // ----------------------------------------------------------------
  assign o_rd_data = cur_ff.rd;
  assign o_rd_dir = cur_ff.dir;
  assign o_rd_pull = cur_ff.pull;
  assign o_bkgd_own = cur_ff.bkgd_own;
  assign o_mode_select = strap_level_ff;
  assign o_pin_sync = cur_ff.sync2;
  assign o_pad = cur_ff.pad;

endmodule // spio_ports

// ---- verification/spio_ports_checker.sv ----
// Checker for the shared parallel I/O ports, bound to the port block.
module spio_ports_checker
  import spio_pkg::*;
(
  // Clock, reset and enable
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_ce,
  // Stimulus seen by the block
  input wire spio_wr_type i_wr,
  input wire spio_periph_type i_periph,
  input wire spio_bytes_type i_pin,
  // Block outputs
  input wire spio_bytes_type o_rd_data,
  input wire spio_bytes_type o_rd_dir,
  input wire spio_bytes_type o_rd_pull,
  input wire logic o_bkgd_own,
  input wire spio_pad_type o_pad
);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rstn);

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  sequence s_dir_wr_e;
    i_ce && i_wr.wr_dir[SPIO_PE];
  endsequence
  // The pin must be steady across the sync stages, so the pipe depth may be two or three.
  sequence s_pin_steady_e;
    $past(i_rstn, 3) && $past(i_pin[SPIO_PE], 2) == $past(i_pin[SPIO_PE], 3);
  endsequence
  property p_dir_wr;
    s_dir_wr_e |=> o_rd_dir[SPIO_PE] == $past(i_wr.wdata);
  endproperty
  property p_drive_e;
    o_pad.oe[SPIO_PE] == $past(o_rd_dir[SPIO_PE]);
  endproperty
  property p_pull_e;
    o_pad.pu[SPIO_PE] == ($past(o_rd_pull[SPIO_PE]) & ~$past(o_rd_dir[SPIO_PE]));
  endproperty
  property p_pin_read;
    s_pin_steady_e ##0 $past(o_rd_dir[SPIO_PE]) == 8'h00 |-> o_rd_data[SPIO_PE] == $past(i_pin[SPIO_PE], 2);
  endproperty
  property p_sci;
    i_ce && i_periph.sci_en |=> o_pad.oe[SPIO_PB][1:0] == 2'h1 && o_pad.out[SPIO_PB][0] == $past(i_periph.sci_tx);
  endproperty

  a_dir_wr: assert property (p_dir_wr) else $error("direction write lost");
  a_drive_e: assert property (p_drive_e) else $error("driver enable off direction");
  a_pull_e: assert property (p_pull_e) else $error("pullup wrong for direction");
  a_pin_read: assert property (p_pin_read) else $error("input read not pin level");
  a_sci: assert property (p_sci) else $error("serial pins not taken");
  a_a0_in: assert property (o_pad.oe[SPIO_PA][0] == 1'b0) else $error("input only pin driven");
  a_d1_rst: assert property (o_pad.oe[SPIO_PD][1] == 1'b0) else $error("reset pin driven");
  a_d7: assert property ({o_rd_data[SPIO_PD][7], o_rd_dir[SPIO_PD][7], o_rd_pull[SPIO_PD][7]} == 3'h0)
    else $error("missing pin bit not zero");
  a_bkgd_pu: assert property (o_bkgd_own && $past(o_bkgd_own) |-> o_pad.pu[SPIO_PD][0])
    else $error("background pin pullup off");
  a_own_kept: assert property (!o_bkgd_own |=> !o_bkgd_own) else $error("background pin reclaimed");
endmodule // spio_ports_checker

bind spio_ports spio_ports_checker u_chk (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_ce(i_ce), .i_wr(i_wr),
  .i_periph(i_periph), .i_pin(i_pin), .o_rd_data(o_rd_data), .o_rd_dir(o_rd_dir), .o_rd_pull(o_rd_pull),
  .o_bkgd_own(o_bkgd_own), .o_pad(o_pad));

// ---- verification/spio_board.sv ----
// Board model: resolves every pad from block drivers, board drivers and pull devices.
module spio_board
  import spio_pkg::*;
(
  // Clock
  input wire logic i_mclk,
  // Block pad controls and board drive
  input wire spio_pad_type i_pad,
  input wire spio_bytes_type i_drv_en,
  input wire spio_bytes_type i_drv_val,
  // Resolved pin levels
  output spio_bytes_type o_pin
);
  logic flt_ff = 1'b0;

  // A floating pin flips every cycle so that it never reads as a steady level.
  always @(posedge i_mclk) begin
    flt_ff <= ~flt_ff;
  end

  // The block driver wins over the board; pulls only act on undriven pins.
  always_comb begin
    for (int p = 0; p < SPIO_NPORTS; p++) begin
      for (int b = 0; b < SPIO_W; b++) begin
        if (i_pad.oe[p][b]) o_pin[p][b] = i_pad.out[p][b];
        else if (i_drv_en[p][b]) o_pin[p][b] = i_drv_val[p][b];
        else if (i_pad.pu[p][b]) o_pin[p][b] = 1'b1;
        else if (i_pad.pd[p][b]) o_pin[p][b] = 1'b0;
        else o_pin[p][b] = flt_ff;
      end
    end
  end
endmodule // spio_board

// ---- verification/spio_ports_tb.sv ----
// Testbench for the shared parallel I/O ports.
module spio_ports_tb import spio_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_mclk = 1'b0;
  logic i_rstn = 1'b0;
  logic i_ce = 1'b1;
  logic i_bkgd_to_gpio = 1'b0;
  spio_wr_type i_wr = '0;
  spio_periph_type i_periph = '0;
  spio_bytes_type pin, o_rd_data, o_rd_dir, o_rd_pull, o_pin_sync, drv_en, drv_val;
  spio_pad_type o_pad;
  logic o_bkgd_own, o_mode_select;
  int miscompares = 0;
  int tests_run = 0;

  // 125 MHz bus clock.
  always #4 i_mclk = ~i_mclk;

  spio_ports uut (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_ce(i_ce), .i_wr(i_wr), .i_bkgd_to_gpio(i_bkgd_to_gpio),
    .i_periph(i_periph), .i_pin(pin), .o_rd_data(o_rd_data), .o_rd_dir(o_rd_dir), .o_rd_pull(o_rd_pull),
    .o_bkgd_own(o_bkgd_own), .o_mode_select(o_mode_select), .o_pin_sync(o_pin_sync), .o_pad(o_pad));
  spio_board u_board (.i_mclk(i_mclk), .i_pad(o_pad), .i_drv_en(drv_en), .i_drv_val(drv_val), .o_pin(pin));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One write cycle; the strobes drop again one edge later.
  task automatic wr(input logic [4:0] d, input logic [4:0] dd, input logic [4:0] pe, input logic [7:0] v);
    @(posedge i_mclk);
    i_wr <= '{wr_data: d, wr_dir: dd, wr_pull: pe, wdata: v};
    @(posedge i_mclk);
    i_wr <= '0;
  endtask
  // Reads that loop through a pad settle on the fourth edge; sample just after it.
  task automatic settle();
    repeat (4) @(posedge i_mclk);
    #1;
  endtask
  task automatic wrap_up();
    if (miscompares == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk(o_rd_dir[SPIO_PE], 8'h00);
    chk(o_rd_pull[SPIO_PC], 8'h00);
    chk(o_pad.oe[SPIO_PB], 8'h00);
    chk({7'h0, o_bkgd_own}, 8'h01);
    chk(o_pad.pu[SPIO_PD], 8'h01);
    @(posedge i_mclk);
    i_rstn <= 1'b1;
    settle();
    settle();
    chk({7'h0, o_mode_select}, 8'h00);
    chk({7'h0, o_bkgd_own}, 8'h01);
    drv_en[SPIO_PD][0] <= 1'b0;
  endtask
  task automatic t_gpio();
    wr(5'h10, 5'h00, 5'h00, 8'ha5);
    wr(5'h00, 5'h10, 5'h00, 8'hff);
    settle();
    chk(o_pad.out[SPIO_PE], 8'ha5);
    chk(o_rd_data[SPIO_PE], 8'ha5);
    wr(5'h00, 5'h10, 5'h00, 8'h0f);
    wr(5'h00, 5'h00, 5'h10, 8'hff);
    wr(5'h10, 5'h00, 5'h00, 8'h3c);
    settle();
    chk(o_rd_data[SPIO_PE], 8'h5c);
    chk(o_pin_sync[SPIO_PE], 8'h5c);
    chk(o_pad.pu[SPIO_PE], 8'hf0);
    chk(o_pad.out[SPIO_PE] & 8'h0f, 8'h0c);
  endtask
  task automatic t_port_d();
    wr(5'h08, 5'h08, 5'h08, 8'hff);
    settle();
    chk(o_rd_dir[SPIO_PD], 8'h7f);
    chk(o_rd_pull[SPIO_PD], 8'h7f);
    chk(o_pad.oe[SPIO_PD], 8'h7c);
    @(posedge i_mclk);
    i_bkgd_to_gpio <= 1'b1;
    @(posedge i_mclk);
    i_bkgd_to_gpio <= 1'b0;
    wr(5'h08, 5'h00, 5'h00, 8'h00);
    settle();
    chk({7'h0, o_bkgd_own}, 8'h00);
    chk(o_pad.oe[SPIO_PD] & 8'h01, 8'h01);
    chk(o_rd_data[SPIO_PD], 8'h02);
  endtask
  task automatic t_periph();
    @(posedge i_mclk);
    i_periph <= '{first_keypad_interrupt_unit_en: 8'hff, first_keypad_interrupt_unit_rise: 8'hf0, second_keypad_interrupt_unit_en: 4'hf, sci_en: 1'b1, sci_tx: 1'b1, tmr1_en: 1'b1,
      tmr1_oe: 1'b1, spi_en: 1'b1, spi_oe: 4'h6, spi_out: 4'hf, tmr0_en: 1'b1, tmr0_oe: 1'b1, tmr0_out: 1'b1,
      default: '0};
    wr(5'h00, 5'h00, 5'h05, 8'hff);
    settle();
    chk(o_pad.oe[SPIO_PB], 8'h81);
    chk(o_pad.out[SPIO_PB] & 8'h81, 8'h01);
    chk(o_pad.oe[SPIO_PC] & 8'hf0, 8'h60);
    chk(o_pad.out[SPIO_PC] & 8'h60, 8'h60);
    chk(o_pad.pu[SPIO_PC] & 8'h90, 8'h90);
    chk(o_pad.out[SPIO_PD] & 8'h40, 8'h40);
    chk(o_pad.pd[SPIO_PA], 8'hf0);
    chk(o_pad.pu[SPIO_PA], 8'h0f);
    // Outputs selected on the claimed pins: keypad claims must keep the drivers off.
    wr(5'h00, 5'h07, 5'h00, 8'hff);
    settle();
    chk(o_rd_data[SPIO_PB] & 8'h01, 8'h00);
    chk(o_pad.out[SPIO_PB] & 8'h01, 8'h01);
    chk(o_pad.oe[SPIO_PA], 8'h00);
    chk(o_pad.oe[SPIO_PC], 8'h60);
  endtask

  // Main sequence: board holds the mode pin low in reset, drives reset pin and port E.
  initial begin
    drv_en = '0;
    drv_val = '0;
    drv_en[SPIO_PD][1:0] = 2'h3;
    drv_val[SPIO_PD][1] = 1'b1;
    drv_en[SPIO_PE] = 8'hff;
    drv_val[SPIO_PE] = 8'h5a;
    repeat (20) @(posedge i_mclk);
    #1;
    t_reset();
    t_gpio();
    t_port_d();
    t_periph();
    wrap_up();
  end
endmodule // spio_ports_tb
